// ### include/flash_sr_pkg.sv
package flash_sr_pkg;

   // ************************************************************
   // instruction codes, one byte each, sent msb first
   // ************************************************************
   localparam logic [7:0] OP_STATUS_READ = 8'h05; // status_read_cmd
   localparam logic [7:0] OP_STATUS_WRITE = 8'h01; // status_write_cmd
   localparam logic [7:0] OP_LATCH_SET = 8'h06; // write_latch_set_cmd
   localparam logic [7:0] OP_LATCH_CLR = 8'h04; // drops the write latch
   localparam logic [7:0] OP_PAGE_WRITE = 8'h02; // page_write_cmd
   localparam logic [7:0] OP_AREA4K_CLEAR = 8'h20; // area4k_clear_cmd
   localparam logic [7:0] OP_BLOCK_CLEAR = 8'hd8; // block_clear_cmd
   localparam logic [7:0] OP_CHIP_CLEAR = 8'hc7; // full-chip erase

   // ************************************************************
   // status byte layout; bits 6 and 5 always read as zero
   // ************************************************************
   localparam int POS_PENDING = 0; // cycle_pending_flag
   localparam int POS_LATCH = 1; // write_latch_flag
   localparam int POS_GUARD_LO = 2; // area_guard_lo
   localparam int POS_GUARD_HI = 4; // area_guard_hi
   localparam int POS_LOCK = 7; // status_lock_bit

   // ************************************************************
   // reset values
   // ************************************************************
   localparam logic [2:0] RST_GUARD = 3'h0;
   localparam logic RST_LOCK = 1'b0;
   localparam logic [7:0] RST_WORD = 8'h00;

   // ************************************************************
   // frame lengths in whole bytes
   // ************************************************************
   localparam logic [2:0] LEN_SHORT = 3'h1; // opcode only
   localparam logic [2:0] LEN_WRITE = 3'h2; // opcode and one data byte
   localparam logic [2:0] LEN_CLEAR = 3'h4; // opcode and address
   localparam logic [2:0] LEN_PROG_MIN = 3'h5; // address and data
   localparam logic [2:0] LEN_SAT = 3'h7; // counter saturates here

   // ************************************************************
   // timing
   // ************************************************************
   localparam int unsigned CLK_PERIOD_NS = 50;
   localparam int unsigned STATUS_WRITE_TIME_NS = 1000000;
   localparam int unsigned STATUS_WRITE_CYCLES =
      (STATUS_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // internal self-timed cycle
   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b00,
      ST_WRITE = 2'b01,
      ST_ARRAY = 2'b10
   } cyc_state_t;

endpackage

// ### logic/flash_status_protect.sv
`timescale 1ns/10ps
// Summary of operation
// - status byte readable at any time
// - status byte repeats while chip select low
// - pending flag high exactly while cycle runs
// - no write latch, no write or erase
// - latch-set instruction sets the write latch
// - guard bits nonvolatile, block guarded area writes; guard bits reset to zero here
// - chip erase only with all guards zero
// - lock and low pin freeze status
// - bits 6,5,1,0 untouched; 6,5 read zero
// - status write needs chip select at byte end
// - chip select rise starts timed write cycle
// - write latch clears when write cycle ends
// - guarded area refuses program and erases
// - lock clear: write allowed whatever pin
// - lock set, pin high: write allowed
// - hard lock entered in either order
// - only pin high leaves hard lock; here a status write begun earlier that clears the lock bit also ends it
// - all serial data msb first
module flash_status_protect
#(
   parameter int unsigned WRITE_CYCLES = flash_sr_pkg::STATUS_WRITE_CYCLES
)
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic serial_in_line,
   input wire logic wp_n,
   input wire logic array_guarded,
   input wire logic array_done,
   output logic dout,
   output logic dout_oe_n,
   output logic [2:0] area_guard,
   output logic hard_lock,
   output logic array_go,
   output logic [7:0] array_op
);

   // ************************************************************
   // declarations
   // ************************************************************
   flash_sr_pkg::cyc_state_t state_q; // self-timed cycle state
   flash_sr_pkg::cyc_state_t state_d;
   logic cs_s1_q, cs_s2_q, cs_s3_q; // chip select sync plus edge
   logic wp_s1_q, wp_s2_q; // protect pin sync
   logic rt_s1_q, rt_s2_q, rt_s3_q; // byte toggle sync plus edge
   logic pa_s1_q, pa_s2_q; // partial-byte level sync
   logic ak_s1_q, ak_s2_q; // publish acknowledge sync
   logic [2:0] nbytes_q; // whole bytes in this frame
   logic [7:0] opc_q; // first byte of the frame
   logic [7:0] dat_q; // second byte of the frame
   logic [7:0] pend_q; // data held for the running write
   logic wel_q; // write_latch_flag
   logic [2:0] bp_q; // area guard bits
   logic lock_q; // status_lock_bit
   logic [31:0] cnt_q; // write cycle timer
   logic [7:0] pub_word_q; // status published to the link
   logic pub_tgl_q;
   wire [7:0] rx_byte; // from link, stable around its toggle
   wire rx_tgl;
   wire partial;
   wire ack_tgl;

   // ************************************************************
   // serial link, on its own clock
   // ************************************************************
   status_link u_link
   (
      .sclk(sclk),
      .rst_n(rst_n),
      .cs_n(cs_n),
      .serial_in_line(serial_in_line),
      .pub_word(pub_word_q),
      .pub_tgl(pub_tgl_q),
      .ack_tgl(ack_tgl),
      .rx_byte(rx_byte),
      .rx_tgl(rx_tgl),
      .partial(partial),
      .dout(dout),
      .dout_oe_n(dout_oe_n)
   );

   // ************************************************************
   // synchronisers; first stages feed only second stages
   // ************************************************************

   // pins and link signals are async to mclk
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cs_s1_q <= 1'b1;
         cs_s2_q <= 1'b1;
         cs_s3_q <= 1'b1;
         wp_s1_q <= 1'b1;
         wp_s2_q <= 1'b1;
         rt_s1_q <= 1'b0;
         rt_s2_q <= 1'b0;
         rt_s3_q <= 1'b0;
         pa_s1_q <= 1'b0;
         pa_s2_q <= 1'b0;
         ak_s1_q <= 1'b0;
         ak_s2_q <= 1'b0;
      end
      else
      begin
         cs_s1_q <= cs_n;
         cs_s2_q <= cs_s1_q;
         cs_s3_q <= cs_s2_q;
         wp_s1_q <= wp_n;
         wp_s2_q <= wp_s1_q;
         rt_s1_q <= rx_tgl;
         rt_s2_q <= rt_s1_q;
         rt_s3_q <= rt_s2_q;
         pa_s1_q <= partial;
         pa_s2_q <= pa_s1_q;
         ak_s1_q <= ack_tgl;
         ak_s2_q <= ak_s1_q;
      end
   end

   // ************************************************************
   // decode
   // ************************************************************
   wire cs_rise = cs_s2_q & ~cs_s3_q;
   wire cs_fall = ~cs_s2_q & cs_s3_q;
   wire rx_evt = rt_s2_q ^ rt_s3_q;
   // rises off a byte boundary void write-type frames
   wire frame_ok = cs_rise & ~pa_s2_q;
   wire idle_w = (state_q == flash_sr_pkg::ST_IDLE);
   wire wip_w = ~idle_w;
   // locked only while the bit is set and the pin is low
   wire hard_lock_w = lock_q & ~wp_s2_q;
   wire len_short = (nbytes_q == flash_sr_pkg::LEN_SHORT);
   wire len_write = (nbytes_q == flash_sr_pkg::LEN_WRITE);
   wire len_clear = (nbytes_q == flash_sr_pkg::LEN_CLEAR);
   wire len_prog = (nbytes_q >= flash_sr_pkg::LEN_PROG_MIN);
   wire op_is_set = (opc_q == flash_sr_pkg::OP_LATCH_SET);
   wire op_is_clr = (opc_q == flash_sr_pkg::OP_LATCH_CLR);
   wire op_is_wr = (opc_q == flash_sr_pkg::OP_STATUS_WRITE);
   wire op_is_pp = (opc_q == flash_sr_pkg::OP_PAGE_WRITE);
   wire op_is_ce = (opc_q == flash_sr_pkg::OP_CHIP_CLEAR);
   wire op_is_ers = (opc_q == flash_sr_pkg::OP_AREA4K_CLEAR) |
      (opc_q == flash_sr_pkg::OP_BLOCK_CLEAR);
   wire write_latch_set_cmd_exec = frame_ok & idle_w & op_is_set & len_short;
   wire wrdi_exec = frame_ok & idle_w & op_is_clr & len_short;
   // latch needed, no running cycle, not hardware locked
   wire status_write_cmd_start = frame_ok & idle_w & op_is_wr & len_write &
      wel_q & ~hard_lock_w;
   // area commands only outside the guarded region
   wire area_ok = ((op_is_pp & len_prog) | (op_is_ers & len_clear)) &
      ~array_guarded;
   wire chip_ok = op_is_ce & len_short &
      (bp_q == flash_sr_pkg::RST_GUARD);
   wire arr_start = frame_ok & idle_w & wel_q &
      (area_ok | chip_ok);
   wire write_end = (state_q == flash_sr_pkg::ST_WRITE) &&
      (cnt_q == 32'h1);
   wire array_end = (state_q == flash_sr_pkg::ST_ARRAY) & array_done;
   // bits 6 and 5 are hard zero
   wire [7:0] stat_w = {lock_q, 2'b00, bp_q, wel_q, wip_w};

   // ************************************************************
   // frame bytes
   // ************************************************************

   // bytes counted per frame; count saturates
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         nbytes_q <= 3'h0;
         opc_q <= 8'h00;
         dat_q <= 8'h00;
      end
      else if (cs_fall)
         nbytes_q <= 3'h0;
      else if (rx_evt)
      begin
         if (nbytes_q == 3'h0)
            opc_q <= rx_byte;
         if (nbytes_q == flash_sr_pkg::LEN_SHORT)
            dat_q <= rx_byte;
         if (nbytes_q != flash_sr_pkg::LEN_SAT)
            nbytes_q <= nbytes_q + 3'h1;
      end
   end

   // ************************************************************
   // self-timed cycle
   // ************************************************************

   // next state of the cycle machine
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         flash_sr_pkg::ST_IDLE:
            if (status_write_cmd_start)
               state_d = flash_sr_pkg::ST_WRITE;
            else if (arr_start)
               state_d = flash_sr_pkg::ST_ARRAY;
         flash_sr_pkg::ST_WRITE:
            if (write_end)
               state_d = flash_sr_pkg::ST_IDLE;
         flash_sr_pkg::ST_ARRAY:
            if (array_end)
               state_d = flash_sr_pkg::ST_IDLE;
         default:
            state_d = flash_sr_pkg::ST_IDLE;
      endcase
   end

   // state, timer and the held write data
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q <= flash_sr_pkg::ST_IDLE;
         cnt_q <= 32'h0;
         pend_q <= 8'h00;
      end
      else
      begin
         state_q <= state_d;
         if (status_write_cmd_start)
         begin
            cnt_q <= 32'(WRITE_CYCLES);
            pend_q <= dat_q;
         end
         else if (cnt_q != 32'h0)
            cnt_q <= cnt_q - 32'h1;
      end
   end

   // ************************************************************
   // status bits
   // ************************************************************

   // guard and lock bits change only at the end of a write cycle;
   // they are nonvolatile in silicon, here they reset to delivery
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wel_q <= 1'b0;
         bp_q <= flash_sr_pkg::RST_GUARD;
         lock_q <= flash_sr_pkg::RST_LOCK;
      end
      else
      begin
         if (write_latch_set_cmd_exec)
            wel_q <= 1'b1;
         else if (wrdi_exec | write_end | array_end)
            wel_q <= 1'b0;
         if (write_end)
         begin
            // bits 1 and 0 of the data are ignored
            bp_q <= pend_q[flash_sr_pkg::POS_GUARD_HI:
               flash_sr_pkg::POS_GUARD_LO];
            lock_q <= pend_q[flash_sr_pkg::POS_LOCK];
         end
      end
   end

   // ************************************************************
   // outputs and status publishing
   // ************************************************************

   // a new word goes out only after the last one was taken;
   // the link clock may stop, so updates can lag until it runs
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pub_word_q <= flash_sr_pkg::RST_WORD;
         pub_tgl_q <= 1'b0;
         area_guard <= flash_sr_pkg::RST_GUARD;
         hard_lock <= 1'b0;
         array_go <= 1'b0;
         array_op <= 8'h00;
      end
      else
      begin
         if (pub_tgl_q == ak_s2_q && stat_w != pub_word_q)
         begin
            pub_word_q <= stat_w;
            pub_tgl_q <= ~pub_tgl_q;
         end
         area_guard <= bp_q;
         hard_lock <= hard_lock_w;
         array_go <= idle_w & arr_start;
         if (idle_w & arr_start)
            array_op <= opc_q;
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   // cycles spent in the write state
   logic [31:0] busy_len_q;
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         busy_len_q <= 32'h0;
      else if (state_q == flash_sr_pkg::ST_WRITE)
         busy_len_q <= busy_len_q + 32'h1;
      else
         busy_len_q <= 32'h0;
   end

   a_cycle_length: assert property (
      (state_q == flash_sr_pkg::ST_WRITE) &&
      (state_d == flash_sr_pkg::ST_IDLE) |->
      busy_len_q == 32'(WRITE_CYCLES) - 32'h1)
      else $error("status write cycle length wrong");
   a_pending_flag: assert property (
      status_write_cmd_start |=> stat_w[flash_sr_pkg::POS_PENDING] [*2])
      else $error("pending flag not set during write");
   a_latch_needed: assert property (
      $rose(wip_w) |-> $past(wel_q))
      else $error("cycle started without write latch");
   a_latch_set: assert property (
      write_latch_set_cmd_exec |=> wel_q ##1 wel_q)
      else $error("write latch not set");
   a_latch_clear: assert property (
      write_end |=> !wel_q && idle_w)
      else $error("write latch not cleared after cycle");
   a_lock_refuse: assert property (
      lock_q && !wp_s2_q |-> !status_write_cmd_start ##1 hard_lock)
      else $error("status write taken while locked");
   a_chip_guard: assert property (
      array_go && array_op == flash_sr_pkg::OP_CHIP_CLEAR |->
      $past(bp_q) == flash_sr_pkg::RST_GUARD)
      else $error("chip erase with guard bits set");
   a_area_guard: assert property (
      array_go && array_op != flash_sr_pkg::OP_CHIP_CLEAR |->
      !$past(array_guarded))
      else $error("guarded area program or erase");
   a_byte_bound: assert property (
      $rose(state_q == flash_sr_pkg::ST_WRITE) |->
      $past(!pa_s2_q) && $past(nbytes_q) == flash_sr_pkg::LEN_WRITE)
      else $error("status write off byte boundary");
   a_busy_ignore: assert property (
      !idle_w |-> !status_write_cmd_start ##1 $stable(pend_q))
      else $error("status write disturbed running cycle");
   a_lock_exit: assert property (
      $fell(hard_lock) |-> $past(wp_s2_q) || $past(!lock_q))
      else $error("hard lock left without pin high");

endmodule

// ### logic/status_link.sv
`timescale 1ns/10ps
// serial side of the status logic; runs on the host's serial clock only
module status_link
(
   input wire logic sclk,
   input wire logic rst_n,
   input wire logic cs_n,
   input wire logic serial_in_line,
   input wire logic [7:0] pub_word,
   input wire logic pub_tgl,
   output logic ack_tgl,
   output logic [7:0] rx_byte,
   output logic rx_tgl,
   output logic partial,
   output logic dout,
   output logic dout_oe_n
);

   // frame logic is cleared whenever chip select is high
   wire frame_rst_n;
   wire byte_end;
   wire [7:0] byte_w;
   logic [2:0] bitcnt_q; // bits taken in the current byte
   logic [6:0] sh_q; // input shift register
   logic first_q; // still inside the opcode byte
   logic rd_q; // status read is streaming out
   logic ps1_q; // publish toggle, first stage
   logic ps2_q; // publish toggle, second stage
   logic [7:0] stat_q; // local copy of the status byte
   logic [7:0] word_q; // output shift register
   logic [2:0] idx_q; // output bit position
   logic seen_q; // last publish toggle taken over

   assign frame_rst_n = rst_n & ~cs_n;
   assign byte_end = (bitcnt_q == 3'h7);
   assign byte_w = {sh_q, serial_in_line};
   // acknowledge is the toggle already copied, so it comes from a flop
   assign ack_tgl = seen_q;

   // ************************************************************
   // input side
   // ************************************************************

   // bits latched on rising edges, msb first
   always_ff @(posedge sclk or negedge frame_rst_n)
   begin
      if (!frame_rst_n)
      begin
         bitcnt_q <= 3'h0;
         sh_q <= 7'h00;
         first_q <= 1'b1;
         rd_q <= 1'b0;
      end
      else
      begin
         sh_q <= byte_w[6:0];
         bitcnt_q <= bitcnt_q + 3'h1;
         if (byte_end)
         begin
            first_q <= 1'b0;
            // read is allowed at any time, busy or not
            if (first_q && byte_w == flash_sr_pkg::OP_STATUS_READ)
               rd_q <= 1'b1;
         end
      end
   end

   // byte hand-off and status copy survive chip select high
   always_ff @(posedge sclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rx_byte <= 8'h00;
         rx_tgl <= 1'b0;
         partial <= 1'b0;
         ps1_q <= 1'b0;
         ps2_q <= 1'b0;
         seen_q <= 1'b0;
         stat_q <= flash_sr_pkg::RST_WORD;
      end
      else
      begin
         ps1_q <= pub_tgl;
         ps2_q <= ps1_q;
         // a flop, not a gate, so the far side never sees glitches
         partial <= ~byte_end;
         if (byte_end)
         begin
            // held stable for eight clocks while the toggle crosses
            rx_byte <= byte_w;
            rx_tgl <= ~rx_tgl;
         end
         if (ps2_q != seen_q)
         begin
            stat_q <= pub_word;
            seen_q <= ps2_q;
         end
      end
   end

   // ************************************************************
   // output side
   // ************************************************************

   // shifted on falling edges, byte repeated while selected
   always_ff @(negedge sclk or negedge frame_rst_n)
   begin
      if (!frame_rst_n)
      begin
         dout <= 1'b0;
         dout_oe_n <= 1'b1;
         idx_q <= 3'h0;
         word_q <= flash_sr_pkg::RST_WORD;
      end
      else if (rd_q)
      begin
         dout_oe_n <= 1'b0;
         idx_q <= idx_q + 3'h1;
         if (idx_q == 3'h0)
         begin
            // fresh copy each byte so a clearing flag shows up
            dout <= stat_q[7];
            word_q <= {stat_q[6:0], 1'b0};
         end
         else
         begin
            dout <= word_q[7];
            word_q <= {word_q[6:0], 1'b0};
         end
      end
   end

endmodule

// ### verification/host_link_model.sv
`timescale 1ns/10ps
// ***********************************************************
// host side of the serial link, 64 ns per bit
// ***********************************************************
module host_link_model
(
   output logic sclk,
   output logic cs_n,
   output logic serial_in_line,
   input wire logic dout,
   input wire logic dout_oe_n
);
   localparam int HALF_NS = 32; // half of the link period
   localparam int GAP_NS = 640; // idle between frames, above 400 ns

   // link clock stands still and select is high outside frames
   initial
   begin
      sclk = 1'b0;
      cs_n = 1'b1;
      serial_in_line = 1'b0;
   end

   // n bits out msb first, then nrd bits read back from dout
   task automatic frame(input logic [39:0] bits, input int n,
                        input int nrd, output logic [15:0] rd);
      rd = 16'h0000;
      cs_n = 1'b0;
      #(HALF_NS);
      for (int i = 0; i < n + nrd; i++)
      begin
         if (i < n)
            serial_in_line = bits[39 - i];
         else
            serial_in_line = ~serial_in_line; // don't care, never stale
         #(HALF_NS);
         // dout was launched on the previous falling edge
         if (i >= n)
            rd = {rd[14:0], dout_oe_n ? 1'bx : dout};
         sclk = 1'b1;
         #(HALF_NS);
         sclk = 1'b0;
      end
      #(HALF_NS);
      cs_n = 1'b1;
      serial_in_line = ~serial_in_line; // released line shows no old bit
      #(GAP_NS);
   endtask
endmodule

// ### verification/testbench.sv
`timescale 1ns/10ps
module testbench;
   // short write cycle (10 us) keeps the run brief but outlasts a frame
   localparam int unsigned WCYC = 200;
   localparam logic [31:0] Z32 = 32'h0000_0000;
   logic mclk, rst_n, wp_n, array_guarded, array_done;
   wire logic sclk, cs_n, serial_in_line, dout, dout_oe_n;
   wire logic hard_lock, array_go;
   wire logic [2:0] area_guard;
   wire logic [7:0] array_op;
   logic [15:0] rd; // bits read back by the host
   logic [7:0] op_seen = 8'h00; // opcode of the last accepted array job
   int error_cnt = 0;
   int n_tests = 0;
   int go_cnt = 0; // accepted array jobs

   flash_status_protect #(.WRITE_CYCLES(WCYC)) dut_u
   (
      .mclk(mclk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n),
      .serial_in_line(serial_in_line), .wp_n(wp_n),
      .array_guarded(array_guarded), .array_done(array_done),
      .dout(dout), .dout_oe_n(dout_oe_n), .area_guard(area_guard),
      .hard_lock(hard_lock), .array_go(array_go), .array_op(array_op)
   );

   host_link_model host_u
   (
      .sclk(sclk), .cs_n(cs_n), .serial_in_line(serial_in_line),
      .dout(dout), .dout_oe_n(dout_oe_n)
   );

   // ***********************************************************
   // clock, monitor and shared tasks
   // ***********************************************************
   initial mclk = 1'b0;
   always #25 mclk = ~mclk;

   // count the one-cycle job pulses
   always @(posedge mclk)
   begin
      if (array_go === 1'b1)
      begin
         go_cnt <= go_cnt + 1;
         op_seen <= array_op;
      end
   end

   task automatic check(input string what, input logic [7:0] seen,
                        input logic [7:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic send(input logic [39:0] bits, input int n);
      host_u.frame(bits, n, 0, rd);
   endtask

   // two whole copies of the status byte in one frame
   task automatic rd_status(input logic [7:0] exp);
      host_u.frame({8'h05, Z32}, 8, 16, rd);
      check("status", rd[15:8], exp);
      check("status repeat", rd[7:0], exp);
      check("oe idle", {7'h00, dout_oe_n}, 8'h01);
   endtask

   // bounded poll of the pending flag
   task automatic wait_idle();
      for (int i = 0; i < 40; i++)
      begin
         host_u.frame({8'h05, Z32}, 8, 8, rd);
         if (rd[0] === 1'b0)
            return;
      end
      error_cnt++;
      $display("FAIL pending expected 0 seen 1");
      results();
   endtask

   task automatic pin(input logic lvl);
      @(negedge mclk);
      wp_n = lvl;
      repeat (6) @(negedge mclk);
   endtask

   task automatic job_end();
      @(negedge mclk);
      array_done = 1'b1;
      @(negedge mclk);
      array_done = 1'b0;
   endtask

   // a hang ends the run as a mismatch
   initial
   begin
      #1000000;
      error_cnt++;
      $display("FAIL run time expected end seen hang");
      results();
   end

   // ***********************************************************
   // main sequence
   // ***********************************************************
   initial
   begin
      rst_n = 1'b0;
      wp_n = 1'b1;
      array_guarded = 1'b0;
      array_done = 1'b0;
      repeat (16) @(negedge mclk);
      rst_n = 1'b1;
      repeat (4) @(negedge mclk);
      rd_status(8'h00);
      send({8'h01, 8'h9c, 24'h0}, 16);
      rd_status(8'h00);
      send({8'h06, Z32}, 8);
      rd_status(8'h02);
      send({8'h01, 8'hff, 24'h0}, 16);
      rd_status(8'h03);
      send({8'h01, 8'h00, 24'h0}, 16);
      wait_idle();
      rd_status(8'h9c);
      check("guards", {5'h00, area_guard}, 8'h07);
      host_u.frame({8'h05, Z32}, 8, 3, rd);
      check("short read", rd[7:0], 8'h04);
      $display("test status write done");
      pin(1'b0);
      check("hard lock", {7'h00, hard_lock}, 8'h01);
      send({8'h06, Z32}, 8);
      send({8'h01, 8'h00, 24'h0}, 16);
      rd_status(8'h9e);
      pin(1'b1);
      check("hard lock", {7'h00, hard_lock}, 8'h00);
      send({8'h01, 8'h00, 24'h0}, 16);
      wait_idle();
      rd_status(8'h00);
      send({8'h06, Z32}, 8);
      send({8'h01, 8'h84, 24'h0}, 15);
      rd_status(8'h02);
      pin(1'b0);
      send({8'h01, 8'h84, 24'h0}, 16);
      wait_idle();
      rd_status(8'h84);
      check("hard lock", {7'h00, hard_lock}, 8'h01);
      pin(1'b1);
      $display("test protect modes done");
      send({8'h06, Z32}, 8);
      send({8'hc7, Z32}, 8);
      check("jobs", go_cnt[7:0], 8'h00);
      @(negedge mclk);
      array_guarded = 1'b1;
      send({8'h20, 24'h001000, 8'h00}, 32);
      check("jobs", go_cnt[7:0], 8'h00);
      @(negedge mclk);
      array_guarded = 1'b0;
      send({8'h20, 24'h001000, 8'h00}, 32);
      check("jobs", go_cnt[7:0], 8'h01);
      check("job op", op_seen, 8'h20);
      rd_status(8'h87);
      job_end();
      wait_idle();
      rd_status(8'h84);
      send({8'h06, Z32}, 8);
      send({8'h01, 8'h00, 24'h0}, 16);
      wait_idle();
      send({8'h06, Z32}, 8);
      send({8'hc7, Z32}, 8);
      check("jobs", go_cnt[7:0], 8'h02);
      check("job op", op_seen, 8'hc7);
      job_end();
      wait_idle();
      $display("test array guard done");
      results();
   end
endmodule
